//--- hw/tcu_pkg.sv
// Shared constants and types for the 16-bit counter with capture and its controller.
package tcu_pkg;

   // ------------------------
   // Device byte register map
   // ------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_CTRL_A = 4'h0;
   localparam logic [3:0] OFS_CTRL_B = 4'h1;
   localparam logic [3:0] OFS_CTRL_C = 4'h2;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
   localparam logic [3:0] OFS_IRQ_FLAGS = 4'h4;
   localparam logic [3:0] OFS_CNT_LO = 4'h5;
   localparam logic [3:0] OFS_CNT_HI = 4'h6;
   localparam logic [3:0] OFS_CAP_LO = 4'h7;
   localparam logic [3:0] OFS_CAP_HI = 4'h8;
   localparam logic [3:0] OFS_CMPA_LO = 4'h9;
   localparam logic [3:0] OFS_CMPA_HI = 4'ha;

   // ------------------------
   // Field positions
   // ------------------------
   localparam int CTRLA_WGM_LSB = 0;
   localparam int CTRLB_CS_LSB = 0;
   localparam int CTRLB_WGM_LSB = 3;
   localparam int CTRLB_EDGE_BIT = 6;
   localparam int CTRLC_SRC_BIT = 0;
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CAP_BIT = 5;

   // ------------------------
   // Count limits, reset values and clock-select codes
   // ------------------------
   localparam logic [15:0] CNT_FLOOR = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CAP_RESET = 16'h0000;
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // ------------------------
   // Controller register map (AXI4-Lite byte addresses)
   // ------------------------
   localparam logic [3:0] HOST_CMD = 4'h0;
   localparam logic [3:0] HOST_STATUS = 4'h4;
   localparam logic [3:0] HOST_ACK = 4'h8;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_WR_BIT = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_ISSUE = 2'b01,
      H_WAIT = 2'b10
   } tcu_hstate_t;

endpackage

//--- hw/tcu_bus_if.sv
// Byte-wide CPU bus between the controller and the counter device.
`timescale 1ns/1ps
`default_nettype none
interface tcu_bus_if;
   logic [3:0] addr;
   logic wrEn;
   logic rdEn;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic rdValid;
   logic ovfIrq;
   logic capIrq;
   logic ovfAck;
   logic capAck;

   modport dev (input addr, input wrEn, input rdEn, input wrData, input ovfAck, input capAck,
                output rdData, output rdValid, output ovfIrq, output capIrq);
   modport host (output addr, output wrEn, output rdEn, output wrData, output ovfAck, output capAck,
                 input rdData, input rdValid, input ovfIrq, input capIrq);
endinterface
`default_nettype wire

//--- hw/tcu_device.sv
// Counter device: 16-bit up/down counter, capture unit and byte register file.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Count high byte reached only through temp.
// - Low read loads temp; low write loads count.
// - Software may reuse one high byte for several.
// - Software disables interrupts across two-byte accesses.
// - Clock select picks tick; zero stops counting.
// - Count readable and writable at any time.
// - CPU count write beats clear and count.
// - Each tick clears, increments or decrements count.
// - Four-bit mode field split over A, B.
// - Overflow flag set where mode defines it.
// - Ceiling and floor signals mark sequence ends.
// - Selected edge on pin or comparator captures.
// - Capture copies count, sets flag same cycle.
// - Enabled flag interrupts; ack or one clears.
// - Capture low read first loads temp.
// - Capture writable only in capture-ceiling modes.
// - Software writes capture high byte before low.
// - One temp byte shared; low access transfers.
// - Floor 0, max FFFF, ceiling per mode.
module tcu_device
   import tcu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   tcu_bus_if.dev bus,
   input wire logic capturePin,
   input wire logic comparatorOut,
   input wire logic extClkPin,
   output logic countCeiling,
   output logic countFloor
);

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] cap;
      logic [15:0] cmpA;
      logic [7:0] temp;
      logic [7:0] ctrlA;
      logic [7:0] ctrlB;
      logic [7:0] ctrlC;
      logic [7:0] mask;
      logic ovfFlag;
      logic capFlag;
      logic down;
      logic capPrev;
      logic extPrev;
      logic [7:0] rdData;
      logic rdValid;
      logic ovfIrq;
      logic capIrq;
      logic atCeil;
      logic atFloor;
   } tcu_dev_t;

   tcu_dev_t st_ff;
   tcu_dev_t nxt_st;

   logic [3:0] wgm;
   logic [2:0] clkSel;
   logic [15:0] ceilVal;
   logic dualSlope;
   logic capIsTop;
   logic ovfAtMax;
   logic tick;
   logic capSrc;
   logic capEdge;
   logic cntWrite;
   logic hitCeil;
   logic hitFloor;
   logic ovfSet;

   // ------------------------
   // Mode decode
   // ------------------------

   // The mode field is assembled from two bits in each of control registers A and B.
   assign wgm = {st_ff.ctrlB[CTRLB_WGM_LSB +: 2], st_ff.ctrlA[CTRLA_WGM_LSB +: 2]};
   assign clkSel = st_ff.ctrlB[CTRLB_CS_LSB +: 3];

   // Ceiling per mode: fixed widths, compare A or the capture register.
   always_comb begin
      unique case (wgm)
         4'h1, 4'h5: ceilVal = TOP_8BIT;
         4'h2, 4'h6: ceilVal = TOP_9BIT;
         4'h3, 4'h7: ceilVal = TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf: ceilVal = st_ff.cmpA;
         4'h8, 4'ha, 4'hc, 4'he: ceilVal = st_ff.cap;
         default: ceilVal = CNT_MAX;
      endcase
   end

   // Dual-slope modes count up to the ceiling and back down to the floor.
   assign dualSlope = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   assign capIsTop = (wgm inside {4'h8, 4'ha, 4'hc, 4'he});
   // Normal and the clear-on-match modes overflow at the absolute maximum.
   assign ovfAtMax = (wgm inside {4'h0, 4'h4, 4'hc});

   // ------------------------
   // Timer tick and capture edge
   // ------------------------

   // Codes 1 to 5 tick every system cycle since no prescaler is built in;
   // the external pin is taken as synchronous and edge detected here.
   always_comb begin
      if (clkSel == CS_STOP) begin
         tick = 1'b0;
      end else if (clkSel == CS_EXT_FALL) begin
         tick = st_ff.extPrev & ~extClkPin;
      end else if (clkSel == CS_EXT_RISE) begin
         tick = ~st_ff.extPrev & extClkPin;
      end else begin
         tick = 1'b1;
      end
   end

   // Capture input is dead while the capture register serves as ceiling.
   assign capSrc = st_ff.ctrlC[CTRLC_SRC_BIT] ? comparatorOut : capturePin;
   assign capEdge = ~capIsTop & (st_ff.ctrlB[CTRLB_EDGE_BIT] ? (~st_ff.capPrev & capSrc)
                                                             : (st_ff.capPrev & ~capSrc));

   assign cntWrite = bus.wrEn & (bus.addr == OFS_CNT_LO);
   assign hitCeil = (st_ff.cnt == ceilVal);
   assign hitFloor = (st_ff.cnt == CNT_FLOOR);

   // ------------------------
   // Next-state logic
   // ------------------------

   // A write to the flag register clears by ones, but a same-cycle event
   // still sets the flag so no capture or overflow is lost.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdValid = 1'b0;
      nxt_st.extPrev = extClkPin;
      nxt_st.capPrev = capSrc;
      ovfSet = 1'b0;

      // Count sequence; a CPU count write overrides it below.
      if (tick) begin
         if (dualSlope) begin
            if (!st_ff.down && hitCeil) begin
               nxt_st.down = 1'b1;
               nxt_st.cnt = st_ff.cnt - 16'h0001;
            end else if (st_ff.down && hitFloor) begin
               nxt_st.down = 1'b0;
               nxt_st.cnt = st_ff.cnt + 16'h0001;
               ovfSet = 1'b1;
            end else if (st_ff.down) begin
               nxt_st.cnt = st_ff.cnt - 16'h0001;
            end else begin
               nxt_st.cnt = st_ff.cnt + 16'h0001;
            end
         end else begin
            nxt_st.down = 1'b0;
            if (hitCeil) begin
               nxt_st.cnt = CNT_FLOOR;
            end else begin
               nxt_st.cnt = st_ff.cnt + 16'h0001;
            end
            if ((ovfAtMax && st_ff.cnt == CNT_MAX) || (!ovfAtMax && hitCeil)) begin
               ovfSet = 1'b1;
            end
         end
      end

      // Byte-bus writes; high locations only load the shared temp byte.
      if (bus.wrEn) begin
         unique case (bus.addr)
            OFS_CTRL_A: nxt_st.ctrlA = bus.wrData;
            OFS_CTRL_B: nxt_st.ctrlB = bus.wrData;
            OFS_CTRL_C: nxt_st.ctrlC = bus.wrData;
            OFS_IRQ_MASK: nxt_st.mask = bus.wrData;
            OFS_IRQ_FLAGS: begin
               if (bus.wrData[FLAG_OVF_BIT]) begin
                  nxt_st.ovfFlag = 1'b0;
               end
               if (bus.wrData[FLAG_CAP_BIT]) begin
                  nxt_st.capFlag = 1'b0;
               end
            end
            OFS_CNT_HI, OFS_CAP_HI, OFS_CMPA_HI: nxt_st.temp = bus.wrData;
            OFS_CNT_LO: nxt_st.cnt = {st_ff.temp, bus.wrData};
            OFS_CAP_LO: begin
               if (capIsTop) begin
                  nxt_st.cap = {st_ff.temp, bus.wrData};
               end
            end
            OFS_CMPA_LO: nxt_st.cmpA = {st_ff.temp, bus.wrData};
            default: nxt_st.temp = st_ff.temp;
         endcase
      end

      // Acknowledges from the CPU's interrupt entry clear the flags.
      if (bus.ovfAck) begin
         nxt_st.ovfFlag = 1'b0;
      end
      if (bus.capAck) begin
         nxt_st.capFlag = 1'b0;
      end

      // Capture copies the pre-update count and sets its flag together.
      if (capEdge) begin
         nxt_st.cap = st_ff.cnt;
         nxt_st.capFlag = 1'b1;
      end
      // Overflow set lands after all clears so that set beats clear.
      if (ovfSet && !cntWrite) begin
         nxt_st.ovfFlag = 1'b1;
      end

      // Byte-bus reads; answer registered one cycle after the strobe.
      if (bus.rdEn) begin
         nxt_st.rdValid = 1'b1;
         unique case (bus.addr)
            OFS_CTRL_A: nxt_st.rdData = st_ff.ctrlA;
            OFS_CTRL_B: nxt_st.rdData = st_ff.ctrlB;
            OFS_CTRL_C: nxt_st.rdData = st_ff.ctrlC;
            OFS_IRQ_MASK: nxt_st.rdData = st_ff.mask;
            OFS_IRQ_FLAGS: begin
               nxt_st.rdData = 8'h00;
               nxt_st.rdData[FLAG_OVF_BIT] = st_ff.ovfFlag;
               nxt_st.rdData[FLAG_CAP_BIT] = st_ff.capFlag;
            end
            OFS_CNT_LO: begin
               nxt_st.rdData = st_ff.cnt[7:0];
               nxt_st.temp = st_ff.cnt[15:8];
            end
            OFS_CAP_LO: begin
               nxt_st.rdData = st_ff.cap[7:0];
               nxt_st.temp = st_ff.cap[15:8];
            end
            OFS_CNT_HI, OFS_CAP_HI: nxt_st.rdData = st_ff.temp;
            OFS_CMPA_LO: nxt_st.rdData = st_ff.cmpA[7:0];
            OFS_CMPA_HI: nxt_st.rdData = st_ff.cmpA[15:8];
            default: nxt_st.rdData = 8'h00;
         endcase
      end

      // Interrupt lines and end markers follow the next state.
      nxt_st.ovfIrq = nxt_st.ovfFlag & nxt_st.mask[FLAG_OVF_BIT];
      nxt_st.capIrq = nxt_st.capFlag & nxt_st.mask[FLAG_CAP_BIT];
      nxt_st.atCeil = (nxt_st.cnt == ceilVal);
      nxt_st.atFloor = (nxt_st.cnt == CNT_FLOOR);
   end

   // ------------------------
   // State register
   // ------------------------

   // Count and capture clear at reset; the whole state freezes on clkEn low.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.cnt <= CNT_RESET;
         st_ff.cap <= CAP_RESET;
         st_ff.atFloor <= 1'b1;
      end else if (clkEn) begin
         st_ff <= nxt_st;
      end
   end

   assign bus.rdData = st_ff.rdData;
   assign bus.rdValid = st_ff.rdValid;
   assign bus.ovfIrq = st_ff.ovfIrq;
   assign bus.capIrq = st_ff.capIrq;
   assign countCeiling = st_ff.atCeil;
   assign countFloor = st_ff.atFloor;

endmodule
`default_nettype wire

//--- hw/tcu_host.sv
// Controller: AXI4-Lite slave that runs single byte accesses on the device bus.
`timescale 1ns/1ps
`default_nettype none
module tcu_host
   import tcu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   tcu_bus_if.host bus,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   typedef struct packed {
      tcu_hstate_t hst;
      logic awHeld;
      logic [3:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awReady;
      logic wReady;
      logic arReady;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [1:0] rResp;
      logic [31:0] rData;
      logic isRead;
      logic [7:0] lastRd;
      logic [3:0] busAddr;
      logic [7:0] busWd;
      logic busWr;
      logic busRd;
      logic ovfAck;
      logic capAck;
   } tcu_host_t;

   tcu_host_t st_ff;
   tcu_host_t nxt_st;

   // ------------------------
   // Next-state logic
   // ------------------------

   // Only one device access runs at a time; a command that arrives while the
   // previous byte access is still running is not started on the device bus.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.busWr = 1'b0;
      nxt_st.busRd = 1'b0;
      nxt_st.ovfAck = 1'b0;
      nxt_st.capAck = 1'b0;

      // Write address and data are taken in either order.
      if (s_axi_awvalid && st_ff.awReady) begin
         nxt_st.awHeld = 1'b1;
         nxt_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wReady) begin
         nxt_st.wHeld = 1'b1;
         nxt_st.wData = s_axi_wdata;
         nxt_st.wStrb = s_axi_wstrb;
      end
      if (st_ff.bValid && s_axi_bready) begin
         nxt_st.bValid = 1'b0;
      end

      // Device bus sequencing.
      unique case (st_ff.hst)
         H_IDLE: nxt_st.hst = H_IDLE;
         H_ISSUE: nxt_st.hst = st_ff.isRead ? H_WAIT : H_IDLE;
         H_WAIT: begin
            if (bus.rdValid) begin
               nxt_st.lastRd = bus.rdData;
               nxt_st.hst = H_IDLE;
            end
         end
         default: nxt_st.hst = H_IDLE;
      endcase

      // Execute a write once both halves are held and the response is free.
      if (st_ff.awHeld && st_ff.wHeld && !st_ff.bValid) begin
         nxt_st.awHeld = 1'b0;
         nxt_st.wHeld = 1'b0;
         nxt_st.bValid = 1'b1;
         nxt_st.bResp = RESP_OKAY;
         if (st_ff.awAddr == HOST_CMD) begin
            // A command while busy is dropped; software polls busy first.
            if (st_ff.hst == H_IDLE && (&st_ff.wStrb[2:0])) begin
               nxt_st.busAddr = st_ff.wData[CMD_ADDR_LSB +: 4];
               nxt_st.busWd = st_ff.wData[7:0];
               nxt_st.isRead = ~st_ff.wData[CMD_WR_BIT];
               nxt_st.busWr = st_ff.wData[CMD_WR_BIT];
               nxt_st.busRd = ~st_ff.wData[CMD_WR_BIT];
               nxt_st.hst = H_ISSUE;
            end
         end else if (st_ff.awAddr == HOST_ACK) begin
            nxt_st.ovfAck = st_ff.wStrb[0] & st_ff.wData[1];
            nxt_st.capAck = st_ff.wStrb[0] & st_ff.wData[0];
         end else if (st_ff.awAddr != HOST_STATUS) begin
            nxt_st.bResp = RESP_SLVERR;
         end
      end

      // Reads answer one cycle after the address is taken.
      if (st_ff.rValid && s_axi_rready) begin
         nxt_st.rValid = 1'b0;
      end
      if (s_axi_arvalid && st_ff.arReady) begin
         nxt_st.rValid = 1'b1;
         nxt_st.rResp = RESP_OKAY;
         nxt_st.rData = 32'h00000000;
         if (s_axi_araddr == HOST_STATUS) begin
            nxt_st.rData = {14'h0000, bus.ovfIrq, bus.capIrq, st_ff.lastRd, 7'h00,
                            (st_ff.hst != H_IDLE)};
         end else if (s_axi_araddr != HOST_CMD && s_axi_araddr != HOST_ACK) begin
            nxt_st.rResp = RESP_SLVERR;
         end
      end

      nxt_st.awReady = ~nxt_st.awHeld & ~nxt_st.bValid;
      nxt_st.wReady = ~nxt_st.wHeld & ~nxt_st.bValid;
      nxt_st.arReady = ~nxt_st.rValid;
   end

   // ------------------------
   // State register
   // ------------------------

   // Ready outputs come up one cycle after reset release.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else if (clkEn) begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = st_ff.awReady;
   assign s_axi_wready = st_ff.wReady;
   assign s_axi_bvalid = st_ff.bValid;
   assign s_axi_bresp = st_ff.bResp;
   assign s_axi_arready = st_ff.arReady;
   assign s_axi_rvalid = st_ff.rValid;
   assign s_axi_rresp = st_ff.rResp;
   assign s_axi_rdata = st_ff.rData;
   assign bus.addr = st_ff.busAddr;
   assign bus.wrData = st_ff.busWd;
   assign bus.wrEn = st_ff.busWr;
   assign bus.rdEn = st_ff.busRd;
   assign bus.ovfAck = st_ff.ovfAck;
   assign bus.capAck = st_ff.capAck;

endmodule
`default_nettype wire

//--- tb/tcu_properties.sv
// Concurrent checks on the byte bus joining the controller and the counter device.
`timescale 1ns/1ps
`default_nettype none
module tcu_properties
   import tcu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic [3:0] addr,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   input wire logic ovfIrq,
   input wire logic capIrq,
   input wire logic ovfAck,
   input wire logic capAck,
   input wire logic countFloor,
   input wire logic countCeiling
);
   // ------------------------
   // One clock domain, one reset.
   // ------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Reads answer one cycle late; no answer without a request.
   property p_rd_answer;
      rdEn && clkEn |=> rdValid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rd_spurious;
      !rdEn && clkEn |=> !rdValid;
   endproperty
   a_rd_spurious: assert property (p_rd_spurious) else $error("answer without read");
   property p_strobe_excl;
      !(wrEn && rdEn);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("read and write together");
   // Read data stands between answers, so a late sample is still valid.
   property p_data_stands;
      !rdValid |-> $stable(rdData);
   endproperty
   a_data_stands: assert property (p_data_stands) else $error("read data moved");
   property p_reset_state;
      $rose(rst_n) |-> countFloor && !countCeiling && !capIrq && !ovfIrq;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
   // Flags hold while nobody writes or acknowledges them.
   property p_cap_hold;
      (capIrq && !capAck && !wrEn) [*2] |=> capIrq;
   endproperty
   a_cap_hold: assert property (p_cap_hold) else $error("capture request dropped");
   property p_ovf_hold;
      (ovfIrq && !ovfAck && !wrEn) [*2] |=> ovfIrq;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("overflow request dropped");
   property p_ack_clears;
      capAck |-> ##[1:2] !capIrq;
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("ack left request up");
endmodule
`default_nettype wire

//--- tb/counter16_with_input_capture_tb_top.sv
// Self-checking bench: AXI4-Lite master, scoreboard and counter scenarios.
`timescale 1ns/1ps
`default_nettype none
module counter16_with_input_capture_tb_top
   import tcu_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic capturePin = 1'b0;
   logic comparatorOut = 1'b0;
   logic extClkPin = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, countCeiling, countFloor;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] expR[$], mskR[$], seed;
   logic [1:0] expB[$];
   logic [15:0] v;
   logic [2:0] csTab[3] = '{CS_STOP, CS_EXT_FALL, CS_EXT_RISE};
   int n_errors = 0;
   int comparisons = 0;

   // ------------------------
   // Ends joined by the byte bus.
   // ------------------------
   tcu_bus_if tcu_bus_if_i ();
   tcu_host tcu_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1), .bus(tcu_bus_if_i.host),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   tcu_device tcu_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1), .bus(tcu_bus_if_i.dev),
      .capturePin(capturePin), .comparatorOut(comparatorOut), .extClkPin(extClkPin),
      .countCeiling(countCeiling), .countFloor(countFloor));
   tcu_properties tcu_properties_i (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1),
      .addr(tcu_bus_if_i.addr), .wrEn(tcu_bus_if_i.wrEn), .rdEn(tcu_bus_if_i.rdEn),
      .rdData(tcu_bus_if_i.rdData), .rdValid(tcu_bus_if_i.rdValid), .ovfIrq(tcu_bus_if_i.ovfIrq),
      .capIrq(tcu_bus_if_i.capIrq), .ovfAck(tcu_bus_if_i.ovfAck), .capAck(tcu_bus_if_i.capAck),
      .countFloor(countFloor), .countCeiling(countCeiling));

   // Free-running 200 MHz clock.
   always #2.5 ref_clk = ~ref_clk;

   // ------------------------
   // Helpers and bus tasks.
   // ------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic chk_rd(input logic [31:0] seen, input logic [31:0] e);
      comparisons++;
      if (seen !== e) begin
         n_errors++;
         $display("FAIL rdata expected %h seen %h", e, seen);
      end
   endtask

   task automatic chk_b(input logic [1:0] seen, input logic [1:0] e);
      comparisons++;
      if (seen !== e) begin
         n_errors++;
         $display("FAIL bresp expected %h seen %h", e, seen);
      end
   endtask

   // Address and data go up together; each drops on its own handshake.
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw = 1'b0;
      logic w = 1'b0;
      expB.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge ref_clk);
         if (awvalid && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (!bvalid);
      bready <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      expR.push_back(e);
      mskR.push_back(m);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge ref_clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge ref_clk);
      rready <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Device byte accesses run as commands; the read byte shows in the status word.
   task automatic dev_wr(input logic [3:0] a, input logic [7:0] d);
      axi_wr(HOST_CMD, {15'h0, 1'b1, 4'h0, a, d}, RESP_OKAY);
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic dev_rd(input logic [3:0] a, input logic [7:0] e);
      axi_wr(HOST_CMD, {20'h0, a, 8'h00}, RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      axi_rd(HOST_STATUS, {16'h0, e, 8'h00}, 32'h0000ff01);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Scoreboard: every answer is matched with the oldest note.
   always @(posedge ref_clk) begin
      if (rvalid && rready && expR.size() > 0) chk_rd(rdata & mskR.pop_front(), expR.pop_front());
      if (bvalid && bready && expB.size() > 0) chk_b(bresp, expB.pop_front());
   end

   // Watchdog: far beyond the roughly one thousand cycles the tests need.
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_errors++;
      tally_and_finish();
   end

   // ------------------------
   // Main sequence.
   // ------------------------
   initial begin
      seed = 32'h36;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      axi_rd(HOST_STATUS, 32'h0, 32'h0003ff01);
      axi_wr(4'hc, 32'h0, RESP_SLVERR);
      dev_rd(OFS_CAP_LO, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         v = seed[15:0];
         dev_wr(OFS_CNT_HI, v[15:8]);
         dev_wr(OFS_CNT_LO, v[7:0]);
         dev_wr(OFS_CMPA_LO, v[7:0]);
         dev_rd(OFS_CMPA_HI, v[15:8]);
         dev_rd(OFS_CNT_LO, v[7:0]);
         dev_rd(OFS_CNT_HI, v[15:8]);
         dev_rd(OFS_CAP_LO, 8'h00);
         dev_rd(OFS_CNT_HI, 8'h00);
      end
      $display("test count access done");
      dev_wr(OFS_CNT_HI, 8'h00);
      dev_wr(OFS_CNT_LO, 8'hfe);
      foreach (csTab[k]) begin
         dev_wr(OFS_CTRL_B, {5'h0, csTab[k]});
         repeat (5) begin
            extClkPin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            extClkPin <= 1'b0;
            repeat (4) @(posedge ref_clk);
         end
         dev_wr(OFS_CTRL_B, 8'h00);
         v = 16'h00fe + 16'(5 * k);
         dev_rd(OFS_CNT_LO, v[7:0]);
         dev_rd(OFS_CNT_HI, v[15:8]);
      end
      $display("test clock select done");
      dev_wr(OFS_IRQ_MASK, 8'h21);
      dev_wr(OFS_CTRL_B, 8'h40);
      capturePin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      axi_rd(HOST_STATUS, 32'h00010000, 32'h00010000);
      dev_rd(OFS_CAP_LO, 8'h08);
      dev_rd(OFS_CAP_HI, 8'h01);
      axi_wr(HOST_ACK, 32'h1, RESP_OKAY);
      capturePin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      axi_rd(HOST_STATUS, 32'h0, 32'h00010000);
      seed = xs(seed);
      v = seed[15:0];
      dev_wr(OFS_CNT_HI, v[15:8]);
      dev_wr(OFS_CNT_LO, v[7:0]);
      dev_wr(OFS_CTRL_C, 8'h01);
      comparatorOut <= 1'b1;
      repeat (6) @(posedge ref_clk);
      dev_rd(OFS_CAP_LO, v[7:0]);
      dev_rd(OFS_CAP_HI, v[15:8]);
      dev_wr(OFS_IRQ_FLAGS, 8'h20);
      axi_rd(HOST_STATUS, 32'h0, 32'h00010000);
      $display("test capture done");
      dev_wr(OFS_CAP_HI, 8'h5a);
      dev_wr(OFS_CAP_LO, 8'ha5);
      dev_rd(OFS_CAP_LO, v[7:0]);
      dev_wr(OFS_CTRL_B, 8'h18);
      dev_wr(OFS_CAP_HI, 8'h5a);
      dev_wr(OFS_CAP_LO, 8'ha5);
      dev_rd(OFS_CAP_LO, 8'ha5);
      dev_rd(OFS_CAP_HI, 8'h5a);
      $display("test capture ceiling done");
      dev_wr(OFS_CTRL_B, 8'h00);
      dev_wr(OFS_CNT_HI, 8'h00);
      dev_wr(OFS_CNT_LO, 8'hf0);
      dev_wr(OFS_CTRL_A, 8'h01);
      dev_wr(OFS_CTRL_B, 8'h09);
      repeat (40) @(posedge ref_clk);
      axi_rd(HOST_STATUS, 32'h00020000, 32'h00020000);
      dev_wr(OFS_CTRL_B, 8'h08);
      axi_wr(HOST_CMD, {20'h0, OFS_CNT_LO, 8'h00}, RESP_OKAY);
      dev_rd(OFS_CNT_HI, 8'h00);
      axi_wr(HOST_ACK, 32'h2, RESP_OKAY);
      axi_rd(HOST_STATUS, 32'h0, 32'h00020000);
      $display("test overflow done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
